/* File: mac_conv_model.sv */
// model of the converter that hands finished raw codes to the path
// assumes go is a one-cycle request from the bench on the same clock
`timescale 1ns/100ps
`default_nettype none
module mac_conv_model (
  // clock
  input wire logic         clock,
  // request
  input wire logic         go,
  input wire logic [3:0]   step,
  input wire logic [15:0]  raw,
  // conversion result
  output var logic         conv_done = 1'b0,
  output var logic [3:0]   conv_step = 4'h0,
  output var logic [15:0]  conv_raw = 16'h0000
);
  // outside the strobe the data lines toggle so stale values never match
  always @(posedge clock) begin
    conv_done <= go;
    conv_step <= go ? step : ~conv_step;
    conv_raw  <= go ? raw : ~conv_raw;
  end
endmodule // mac_conv_model
`default_nettype wire

/* File: mac_defs.vh */
// constants for the calibrated result path of the sequenced converter
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef MAC_DEFS_VH
`define MAC_DEFS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define MAC_IDX_OFFSET   6'h01
`define MAC_IDX_GAIN     6'h02
`define MAC_IDX_CTRL     6'h03
`define MAC_IDX_SEL_LO   6'h04
`define MAC_IDX_SEL_HI   6'h05
`define MAC_IDX_STATUS   6'h06
`define MAC_IDX_RES_LO   6'h10
`define MAC_IDX_RES_HI   6'h1f

// ****************************************
// fields and reset values
// ****************************************
`define MAC_CTRL_BIAS_BIT  0
`define MAC_CTRL_NEG7_BIT  1
`define MAC_OFFSET_RST     16'h0000
`define MAC_GAIN_RST       16'h0000
`define MAC_CTRL_RST       2'h0
`define MAC_SEL_RST        64'h0000000000000000

// ****************************************
// multiplexer codes and arithmetic limits
// ****************************************
`define MAC_SEL_SHORT      4'h9
`define MAC_SEL_TEMP       4'h8
`define MAC_SEL_LAST_PDIFF 4'h6
`define MAC_SEL_LAST_AIN   4'h7
`define MAC_UNITY          18'sh10000
`define MAC_ROUND_HALF     35'sh000008000
`define MAC_CODE_MAX       19'sh07fff
`define MAC_CODE_MIN       19'sh78000

`endif

/* File: mac_path.v */
// calibrated result path: offset, gain, round, clip, store per step
// assumes conversion strobes and sequencer step come from logic on clock
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "mac_defs.vh"

module mac_path (
  // clock and reset
  input  wire        clock,
  input  wire        resetn,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // sequencer side
  input  wire [3:0]  seq_step,
  input  wire        conv_done,
  input  wire [3:0]  conv_step,
  input  wire [15:0] conv_raw,
  // analog front-end controls
  output reg  [3:0]  mux_pos_sel_q,
  output reg         mux_neg_ch7_q,
  output reg         short_to_ground_q,
  output reg         bias_to_ch7_q,
  // result strobe
  output reg         result_wr_q,
  output reg  [3:0]  result_step_q,
  output reg  [15:0] result_data_q
);

  // ****************************************
  // reset release
  // ****************************************
  reg rst_meta_q;
  reg rst_n_q;

  // async assert, release through two flops
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg  [15:0] offset_correction_value_q;
  reg  [15:0] gain_correction_value_q;
  reg  [1:0]  ctrl_q;
  reg  [63:0] step_sel_q;
  reg  [3:0]  last_step_q;
  reg         any_result_q;
  reg         pend_q;
  wire [15:0] mem_rd_data;
  wire [5:0]  idx = wb_adr_i[7:2];
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // the write lands on the edge where the master samples ack high
  wire        do_wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
  reg  [31:0] rd_mux;

  // read selection; unmapped words read as zero
  always @* begin
    rd_mux = 32'h00000000;
    if (idx == `MAC_IDX_OFFSET) begin
      rd_mux = {16'h0000, offset_correction_value_q};
    end else if (idx == `MAC_IDX_GAIN) begin
      rd_mux = {16'h0000, gain_correction_value_q};
    end else if (idx == `MAC_IDX_CTRL) begin
      rd_mux = {30'h00000000, ctrl_q};
    end else if (idx == `MAC_IDX_SEL_LO) begin
      rd_mux = step_sel_q[31:0];
    end else if (idx == `MAC_IDX_SEL_HI) begin
      rd_mux = step_sel_q[63:32];
    end else if (idx == `MAC_IDX_STATUS) begin
      rd_mux = {27'h0000000, any_result_q, last_step_q};
    end else if (idx >= `MAC_IDX_RES_LO && idx <= `MAC_IDX_RES_HI) begin
      rd_mux = {16'h0000, mem_rd_data};
    end
  end

  // two-edge answer: the memory read needs the pending cycle
  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q   <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      pend_q   <= wb_cyc_i & wb_stb_i & ~pend_q & ~wb_ack_o;
      wb_ack_o <= pend_q & ~wb_ack_o;
      if (pend_q & ~wb_ack_o & ~wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // writable words honour byte lanes; result words are read-only
  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      offset_correction_value_q <= `MAC_OFFSET_RST;
      gain_correction_value_q   <= `MAC_GAIN_RST;
      ctrl_q                    <= `MAC_CTRL_RST;
      step_sel_q                <= `MAC_SEL_RST;
    end else if (do_wr) begin
      if (idx == `MAC_IDX_OFFSET) begin
        offset_correction_value_q <=
          (offset_correction_value_q & ~wmask[15:0]) |
          (wb_dat_i[15:0] & wmask[15:0]);
      end else if (idx == `MAC_IDX_GAIN) begin
        gain_correction_value_q <=
          (gain_correction_value_q & ~wmask[15:0]) |
          (wb_dat_i[15:0] & wmask[15:0]);
      end else if (idx == `MAC_IDX_CTRL) begin
        if (wb_sel_i[0]) begin
          ctrl_q <= wb_dat_i[1:0];
        end
      end else if (idx == `MAC_IDX_SEL_LO) begin
        step_sel_q[31:0] <= (step_sel_q[31:0] & ~wmask) |
                            (wb_dat_i & wmask);
      end else if (idx == `MAC_IDX_SEL_HI) begin
        step_sel_q[63:32] <= (step_sel_q[63:32] & ~wmask) |
                             (wb_dat_i & wmask);
      end
    end
  end

  // ****************************************
  // front-end multiplexer control
  // ****************************************
  wire [3:0] cur_sel = step_sel_q[{seq_step, 2'b00} +: 4];

  // non-analog selections force the negative side to ground
  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mux_pos_sel_q     <= 4'h0;
      mux_neg_ch7_q     <= 1'b0;
      short_to_ground_q <= 1'b0;
      bias_to_ch7_q     <= 1'b0;
    end else begin
      mux_pos_sel_q     <= cur_sel;
      short_to_ground_q <= (cur_sel == `MAC_SEL_SHORT);
      mux_neg_ch7_q     <= ctrl_q[`MAC_CTRL_NEG7_BIT] &
                           (cur_sel <= `MAC_SEL_LAST_PDIFF);
      bias_to_ch7_q     <= ctrl_q[`MAC_CTRL_BIAS_BIT];
    end
  end

  // ****************************************
  // correction pipeline
  // ****************************************
  reg               s1_vld_q;
  reg  [3:0]        s1_step_q;
  reg               s1_bypass_q;
  reg  signed [16:0] s1_diff_q;
  reg  [15:0]       s1_raw_q;
  reg               s2_vld_q;
  reg  [3:0]        s2_step_q;
  reg               s2_bypass_q;
  reg  [15:0]       s2_raw_q;
  reg  signed [34:0] s2_prod_q;

  wire signed [16:0] raw_s = {conv_raw[15], conv_raw};
  wire signed [16:0] ofs_s = {offset_correction_value_q[15],
                              offset_correction_value_q};
  // unity plus signed parts in 2^16; 8000h lands on exactly one half
  wire signed [17:0] factor = `MAC_UNITY +
    {{2{gain_correction_value_q[15]}}, gain_correction_value_q};
  wire signed [34:0] prod = s1_diff_q * factor;
  wire signed [34:0] prod_r = s2_prod_q + `MAC_ROUND_HALF;
  wire signed [18:0] scaled = prod_r[34:16];
  reg  [15:0]        clipped;

  // saturate to full-scale codes
  always @* begin
    clipped = scaled[15:0];
    if (scaled > `MAC_CODE_MAX) begin
      clipped = 16'h7fff;
    end else if (scaled < `MAC_CODE_MIN) begin
      clipped = 16'h8000;
    end
  end

  // stage one: subtract offset, note bypass for temperature sensor
  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s1_vld_q    <= 1'b0;
      s1_step_q   <= 4'h0;
      s1_bypass_q <= 1'b0;
      s1_diff_q   <= 17'sh00000;
      s1_raw_q    <= 16'h0000;
    end else begin
      s1_vld_q <= conv_done;
      if (conv_done) begin
        s1_step_q   <= conv_step;
        s1_bypass_q <= (step_sel_q[{conv_step, 2'b00} +: 4] ==
                        `MAC_SEL_TEMP);
        s1_diff_q   <= raw_s - ofs_s;
        s1_raw_q    <= conv_raw;
      end
    end
  end

  // stage two: scale; the product is registered to relieve timing
  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s2_vld_q    <= 1'b0;
      s2_step_q   <= 4'h0;
      s2_bypass_q <= 1'b0;
      s2_raw_q    <= 16'h0000;
      s2_prod_q   <= 35'sh000000000;
    end else begin
      s2_vld_q <= s1_vld_q;
      if (s1_vld_q) begin
        s2_step_q   <= s1_step_q;
        s2_bypass_q <= s1_bypass_q;
        s2_raw_q    <= s1_raw_q;
        s2_prod_q   <= prod;
      end
    end
  end

  // stage three: round, clip and publish
  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      result_wr_q   <= 1'b0;
      result_step_q <= 4'h0;
      result_data_q <= 16'h0000;
      last_step_q   <= 4'h0;
      any_result_q  <= 1'b0;
    end else begin
      result_wr_q <= s2_vld_q;
      if (s2_vld_q) begin
        result_step_q <= s2_step_q;
        result_data_q <= s2_bypass_q ? s2_raw_q : clipped;
        last_step_q   <= s2_step_q;
        any_result_q  <= 1'b1;
      end
    end
  end

  // ****************************************
  // result storage
  // ****************************************
  mac_result_mem u_mem (
    .clock     (clock),
    .wr_en     (result_wr_q),
    .wr_addr   (result_step_q),
    .wr_data   (result_data_q),
    .rd_addr   (wb_adr_i[5:2]),
    .rd_data_q (mem_rd_data)
  );

endmodule // mac_path

`default_nettype wire

/* File: mac_path_asserts.sv */
// checker for the calibrated result path: bus, conversion and mux timing
// assumes it is bound onto mac_path and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module mac_path_asserts (
  // clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // bus handshake
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // conversion side
  input wire logic        conv_done,
  input wire logic [3:0]  conv_step,
  input wire logic        result_wr_q,
  input wire logic [3:0]  result_step_q,
  input wire logic [15:0] result_data_q,
  // front-end controls
  input wire logic [3:0]  mux_pos_sel_q,
  input wire logic        mux_neg_ch7_q,
  input wire logic        short_to_ground_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ack follows a fresh request by two edges and lasts one cycle
  AST_ACK_LAT: assert property (
    $rose(wb_cyc_i && wb_stb_i) |-> ##2 wb_ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i, 2))
    else $error("ack without request");
  // the three-stage pipeline publishes each conversion exactly once
  AST_RES_LAT: assert property (
    conv_done |-> ##3 result_wr_q)
    else $error("result strobe late");
  AST_RES_CAUSE: assert property (
    result_wr_q |-> $past(conv_done, 3))
    else $error("result strobe without conversion");
  AST_RES_STEP: assert property (
    conv_done |-> ##3 result_step_q == $past(conv_step, 3))
    else $error("result step wrong");
  AST_RES_HOLD: assert property (
    !result_wr_q |-> $stable(result_data_q))
    else $error("result changed without strobe");
  // front-end selections stay consistent with the step code
  AST_NEG7: assert property (
    mux_neg_ch7_q |-> mux_pos_sel_q <= 4'h6)
    else $error("channel seven negative on bad input");
  AST_SHORT: assert property (
    short_to_ground_q |-> mux_pos_sel_q == 4'h9)
    else $error("short without short code");
endmodule // mac_path_asserts
bind mac_path mac_path_asserts u_chk (.clock(clock), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .conv_done(conv_done), .conv_step(conv_step), .result_wr_q(result_wr_q),
  .result_step_q(result_step_q), .result_data_q(result_data_q),
  .mux_pos_sel_q(mux_pos_sel_q), .mux_neg_ch7_q(mux_neg_ch7_q),
  .short_to_ground_q(short_to_ground_q));
`default_nettype wire

/* File: mac_result_mem.v */
// sixteen result words, one write port, registered read port
// assumes one clock; read data follows the address by one edge
`timescale 1ns/100ps
`default_nettype none

module mac_result_mem (
  // clock
  input  wire        clock,
  // write side
  input  wire        wr_en,
  input  wire [3:0]  wr_addr,
  input  wire [15:0] wr_data,
  // read side
  input  wire [3:0]  rd_addr,
  output reg  [15:0] rd_data_q
);

  reg [15:0] mem_q [0:15];

  // no reset: contents are undefined until each step first converts
  always @(posedge clock) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= mem_q[rd_addr];
  end

endmodule // mac_result_mem

`default_nettype wire

/* File: mux_adc_cal_output_path_tb_top.sv */
// bench for the calibrated result path over classic wishbone
// assumes mac_path, the converter model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module mux_adc_cal_output_path_tb_top;
  logic clock = 0, resetn = 0, cyc = 0, stb = 0, we = 0, go = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic [3:0]  seq = 4'h0, gs = 4'h0, cstep, mpos, rstep;
  logic [15:0] graw = 16'h0, craw, rdata;
  logic ack, cdone, neg7, shrt, bias, rwr;
  int n_fail = 0, total_checks = 0, n_cyc = 0;
  always #4 clock = ~clock;
  // hang guard, well above the length of the sequence
  always @(posedge clock) begin
    n_cyc++;
    if (n_cyc > 20000) begin
      n_fail++;
      final_report;
    end
  end
  mac_conv_model model (.clock(clock), .go(go), .step(gs), .raw(graw),
    .conv_done(cdone), .conv_step(cstep), .conv_raw(craw));
  mac_path uut (.clock(clock), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .seq_step(seq),
    .conv_done(cdone), .conv_step(cstep), .conv_raw(craw),
    .mux_pos_sel_q(mpos), .mux_neg_ch7_q(neg7), .short_to_ground_q(shrt),
    .bias_to_ch7_q(bias), .result_wr_q(rwr), .result_step_q(rstep),
    .result_data_q(rdata));
  task final_report;
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle: hold everything until ack is sampled
  task wb(input logic w, input logic [5:0] i, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    dat <= d;
    // no cycle count assumed: only the hang guard ends this wait
    do @(posedge clock); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // expected code: subtract, scale, round half up, clip
  function logic [15:0] ex(input logic [15:0] r, o, g, input logic t);
    longint p;
    if (t) return r;
    p = (longint'($signed(r)) - $signed(o)) * (65536 + longint'($signed(g)));
    p = (p + 32768) >>> 16;
    return p > 32767 ? 16'h7fff : p < -32768 ? 16'h8000 : p[15:0];
  endfunction
  task cal(input logic [15:0] o, g, input logic [3:0] c, s,
           input logic [15:0] r);
    wb(1, 6'h01, {16'h0, o});
    wb(1, 6'h02, {16'h0, g});
    wb(1, s[3] ? 6'h05 : 6'h04, {28'h0, c} << (4 * s[2:0]));
    @(posedge clock);
    seq <= s; gs <= s; graw <= r; go <= 1;
    @(posedge clock);
    go <= 0;
    repeat (6) @(posedge clock);
    wb(0, 6'h10 + s, 0);
    chk(q, {16'h0, ex(r, o, g, c == 4'h8)});
  endtask
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1;
    repeat (4) @(posedge clock);
    cal(16'h0, 16'h0, 4'h0, 4'h0, 16'h0000);
    cal(16'h0, 16'h0, 4'h0, 4'h1, 16'h0001);
    cal(16'h0, 16'h0, 4'h0, 4'h2, 16'hffff);
    cal(16'h0, 16'h8000, 4'h0, 4'h3, 16'h0100);
    cal(16'h0, 16'h199a, 4'h0, 4'h4, 16'h6fb6);
    cal(16'h0010, 16'h0, 4'h0, 4'h5, 16'h0020);
    cal(16'hffff, 16'h0, 4'h0, 4'h6, 16'h7fff);
    cal(16'h0001, 16'h0, 4'h0, 4'h7, 16'h8000);
    cal(16'h0010, 16'h7fff, 4'h8, 4'h8, 16'h0020);
    cal(16'h0010, 16'h0, 4'h9, 4'hf, 16'h0030);
    chk(shrt, 1);
    chk(rdata, 32'h20);
    chk(rstep, 32'hf);
    wb(0, 6'h06, 0);
    chk(q, 32'h1f);
    wb(1, 6'h03, 32'h3);
    seq <= 4'h5;
    repeat (3) @(posedge clock);
    chk(bias, 1);
    chk(neg7, 1);
    seq <= 4'hf;
    repeat (3) @(posedge clock);
    chk(neg7, 0);
    chk(mpos, 32'h9);
    wb(1, 6'h1f, 32'h0);
    wb(0, 6'h1f, 0);
    chk(q, 32'h20);
    wb(0, 6'h10, 0);
    chk(q, 32'h0);
    wb(0, 6'h3f, 0);
    chk(q, 32'h0);
    final_report;
  end
endmodule // mux_adc_cal_output_path_tb_top
`default_nettype wire
